// ---- verilog/prot_host.sv ----
/*
 Host sequencer that protects, unprotects and verifies flash sectors
 through the high-voltage select pins and control strobes.
 Assumes an external driver turns the hv_* enables into the elevated
 select level and that the data lines are sampled asynchronously.
*/
// Operation
// - protect: we high, ce low, elevate
// - other address and data held stable
// - protect write strobe low 100 us
// - protect all sectors before unprotect
// - unprotect: elevate oe, ce, set bits
// - unprotect write strobe low 10 ms
`timescale 1ns/10ps
`default_nettype none
module prot_host #(
	parameter int PROT_CYC   = prot_pkg::PROT_PULSE_CYC,
	parameter int UNPROT_CYC = prot_pkg::UNPROT_PULSE_CYC
) (
	input  wire logic                   CLOCK,
	input  wire logic                   RST_N,
	input  wire logic                   CMD_VALID,
	output logic                        CMD_READY,
	input  wire prot_pkg::prot_cmd_e    CMD_OP,
	input  wire logic [2:0]             CMD_SECTOR,
	output logic                        DONE,
	output logic                        PROTECTED,
	output prot_pkg::flash_pins_s       PINS,
	input  wire logic [7:0]             DATA_IN,
	output logic [7:0]                  DATA_OUT,
	output logic                        DATA_OE_N
);
	localparam int TW = 32;

	typedef enum {
		ST_IDLE,
		ST_SETUP,
		ST_PULSE,
		ST_RECOVER,
		ST_READ
	} state_e;

	state_e              state_ff;
	prot_pkg::prot_cmd_e op_ff;
	logic [2:0]          sect_ff;
	logic [7:0]          data_m_ff;
	logic [7:0]          data_s_ff;
	logic                tload;
	logic [TW-1:0]       tval;
	logic                tdone;
	logic                is_write;
	logic [7:0]          armed_ff;
	logic                skip;

	pulse_timer #(.W(TW)) u_timer (
		.clk   (CLOCK),
		.rst_n (RST_N),
		.load  (tload),
		.value (tval),
		.done  (tdone)
	);

	// two-stage synchroniser on the data lines
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			data_m_ff <= 8'h00;
			data_s_ff <= 8'h00;
		end else begin
			data_m_ff <= DATA_IN;
			data_s_ff <= data_m_ff;
		end
	end

	assign is_write = (op_ff == prot_pkg::CMD_PROTECT) ||
	                  (op_ff == prot_pkg::CMD_UNPROTECT);

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			armed_ff <= '0;
		end else if (state_ff == ST_PULSE && tdone) begin
			if (op_ff == prot_pkg::CMD_PROTECT)
				armed_ff[sect_ff] <= 1'b1;
			else if (op_ff == prot_pkg::CMD_UNPROTECT)
				armed_ff <= '0;
		end
	end

	// an early unprotect runs setup and recovery but never strobes
	assign skip = (op_ff == prot_pkg::CMD_UNPROTECT) && !(&armed_ff);

	function automatic logic [TW-1:0] pulse_len(prot_pkg::prot_cmd_e o);
		logic [TW-1:0] r;
		r = TW'(prot_pkg::SETUP_CYC);
		if (o == prot_pkg::CMD_PROTECT)
			r = TW'(PROT_CYC);
		else if (o == prot_pkg::CMD_UNPROTECT)
			r = TW'(UNPROT_CYC);
		return r;
	endfunction : pulse_len

	always_comb begin
		tload = 1'b0;
		tval  = TW'(prot_pkg::SETUP_CYC);
		case (state_ff)
		ST_IDLE: begin
			tload = CMD_VALID;
		end
		ST_SETUP: begin
			tload = tdone;
			tval  = skip ? TW'(prot_pkg::SETUP_CYC) : pulse_len(op_ff);
		end
		ST_PULSE: begin
			tload = tdone;
		end
		default: begin
			tload = 1'b0;
		end
		endcase
	end

	// sequencing: setup, then strobe and recovery, or read window and one read cycle
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			state_ff <= ST_IDLE;
			op_ff    <= prot_pkg::CMD_VERIFY_P;
			sect_ff  <= 3'h0;
		end else begin
			case (state_ff)
			ST_IDLE: begin
				if (CMD_VALID) begin
					op_ff    <= CMD_OP;
					sect_ff  <= CMD_SECTOR;
					state_ff <= ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (tdone)
					state_ff <= skip ? ST_RECOVER : ST_PULSE;
			end
			ST_PULSE: begin
				if (tdone)
					state_ff <= is_write ? ST_RECOVER : ST_READ;
			end
			ST_RECOVER: begin
				if (tdone)
					state_ff <= ST_IDLE;
			end
			ST_READ: begin
				state_ff <= ST_IDLE;
			end
			default: begin
				state_ff <= ST_IDLE;
			end
			endcase
		end
	end

	// pin drive; address and data held for the whole operation
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			PINS <= '{addr: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
			          hv_addr: 1'b0, hv_oe: 1'b0, hv_ce: 1'b0};
		end else if (state_ff == ST_IDLE && CMD_VALID) begin
			PINS      <= '{addr: '0, ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b1,
			               hv_addr: 1'b1, hv_oe: 1'b0, hv_ce: 1'b0};
			PINS.addr[prot_pkg::SECT_LSB +: 3] <= CMD_SECTOR;
			case (CMD_OP)
			prot_pkg::CMD_PROTECT: begin
				PINS.hv_oe <= 1'b1;
			end
			prot_pkg::CMD_UNPROTECT: begin
				PINS.hv_oe                  <= 1'b1;
				PINS.hv_ce                  <= 1'b1;
				PINS.ce_n                   <= 1'b1;
				PINS.addr[prot_pkg::BIT_A6]  <= 1'b1;
				PINS.addr[prot_pkg::BIT_A12] <= 1'b1;
				PINS.addr[prot_pkg::BIT_A16] <= 1'b1;
			end
			prot_pkg::CMD_VERIFY_P: begin
				PINS.addr[prot_pkg::BIT_A1] <= 1'b1;
			end
			default: begin
				PINS.addr[prot_pkg::BIT_A1] <= 1'b1;
				PINS.addr[prot_pkg::BIT_A6] <= 1'b1;
			end
			endcase
		end else if (state_ff == ST_SETUP && tdone && !skip) begin
			if (is_write)
				PINS.we_n <= 1'b0;
			else
				PINS.oe_n <= 1'b0;
		end else if (state_ff == ST_PULSE && tdone) begin
			PINS.we_n <= 1'b1;
			PINS.oe_n <= 1'b1;
		end else if (state_ff == ST_RECOVER && tdone ||
		             state_ff == ST_READ) begin
			PINS.ce_n    <= 1'b1;
			PINS.hv_addr <= 1'b0;
			PINS.hv_oe   <= 1'b0;
			PINS.hv_ce   <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			DATA_OUT  <= 8'h00;
			DATA_OE_N <= 1'b1;
		end else begin
			DATA_OUT  <= 8'h00;
			DATA_OE_N <= !(state_ff != ST_IDLE && is_write);
		end
	end

	// result; read sampled late so the synchroniser has settled
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			DONE      <= 1'b0;
			PROTECTED <= 1'b0;
		end else begin
			DONE <= (state_ff == ST_RECOVER && tdone) ||
			        (state_ff == ST_READ);
			if (state_ff == ST_READ)
				PROTECTED <= (data_s_ff == prot_pkg::VERIFY_PROT);
		end
	end

	assign CMD_READY = (state_ff == ST_IDLE);
endmodule : prot_host
`default_nettype wire

// ---- inc/prot_pkg.sv ----
/*
 Package for the host-side sector protection sequencer: pin carriers,
 command codes, address bit positions and timing constants.
 Assumes a 100 MHz clock and a flash with eight sectors, byte-wide data.
*/
package prot_pkg;
	localparam int  CLK_MHZ        = 100;
	localparam int  ADDR_W         = 19;
	// pulse widths as printed
	localparam int  PROT_PULSE_US  = 100;
	localparam int  UNPROT_PULSE_MS = 10;
	localparam int  SETUP_NS       = 200;
	localparam int  PROT_PULSE_CYC = PROT_PULSE_US * CLK_MHZ;
	localparam int  UNPROT_PULSE_CYC = UNPROT_PULSE_MS * 1000 * CLK_MHZ;
	localparam int  SETUP_CYC      = (SETUP_NS * CLK_MHZ + 999) / 1000;
	// address bit positions
	localparam int  BIT_A0         = 0;
	localparam int  BIT_A1         = 1;
	localparam int  BIT_A6         = 6;
	localparam int  BIT_A12        = 12;
	localparam int  BIT_A16        = 16;
	localparam int  SECT_LSB       = 16;
	localparam logic [7:0] VERIFY_PROT = 8'h01;

	typedef enum logic [1:0] {
		CMD_PROTECT,
		CMD_UNPROTECT,
		CMD_VERIFY_P,
		CMD_VERIFY_U
	} prot_cmd_e;

	// pins toward the flash; high-voltage selects are separate enables
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              ce_n;
		logic              oe_n;
		logic              we_n;
		logic              hv_addr;
		logic              hv_oe;
		logic              hv_ce;
	} flash_pins_s;
endpackage : prot_pkg

// ---- verilog/pulse_timer.sv ----
/*
 Down-counter that measures one timed phase of the sequencer.
 Assumes a single clock; load and count come from the same domain.
*/
`timescale 1ns/10ps
`default_nettype none
module pulse_timer #(
	parameter int W = 24
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	output logic              done
);
	logic [W-1:0] cnt_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
		end else if (load) begin
			// one less, so a phase lasts exactly value cycles
			cnt_ff <= value - W'(1);
		end else if (cnt_ff != '0) begin
			cnt_ff <= cnt_ff - W'(1);
		end
	end

	// no load term: the sequencer loads on done, which would loop
	assign done = (cnt_ff == '0);
endmodule : pulse_timer
`default_nettype wire

// ---- sim/flash_model.sv ----
/* flash model: eight protect bits and verify read-back.
 assumes hv_* flags stand for the elevated select level */
`timescale 1ns/10ps
`default_nettype none
module flash_model (
	input  wire logic                  clk,
	input  wire prot_pkg::flash_pins_s pins,
	input  wire logic [7:0]            dout,
	input  wire logic                  dout_oe_n,
	output logic [7:0]                 din
);
	logic [7:0] prot_ff = 8'h00;
	logic       we_q = 1'b1;
	// a strobe low since power-up gives no command
	logic       armed = 1'b0;
	logic [7:0] pat_ff = 8'h5A;
	// strobes seen only at clock edges, glitches drop out
	always @(posedge clk) begin
		we_q <= pins.we_n;
		armed <= armed | pins.we_n;
		pat_ff <= ~pat_ff;
	end
	always @(posedge clk) begin
		if (pins.we_n && !we_q && armed) begin
			if (pins.hv_ce && pins.addr[6] && pins.addr[12] && pins.addr[16])
				prot_ff <= 8'h00;
			else if (pins.hv_addr && pins.hv_oe && !pins.ce_n)
				prot_ff[pins.addr[18:16]] <= 1'b1;
		end
	end
	// supply taken as above lockout, so always read state
	// released lines show a changing pattern, never the last value
	assign din = !dout_oe_n ? dout
		: (!pins.oe_n && !pins.ce_n && pins.hv_addr)
		? {7'h00, prot_ff[pins.addr[18:16]]} : pat_ff;
endmodule : flash_model
`default_nettype wire

// ---- sim/prot_host_props.sv ----
/* checker for the protection sequencer pins.
 bound to prot_host; sees only its ports */
`timescale 1ns/10ps
`default_nettype none
module prot_host_props #(
	parameter int PROT_CYC   = 50,
	parameter int UNPROT_CYC = 100
) (
	input wire logic                  CLOCK,
	input wire logic                  RST_N,
	input wire logic                  CMD_VALID,
	input wire logic                  CMD_READY,
	input wire prot_pkg::prot_cmd_e   CMD_OP,
	input wire logic [2:0]            CMD_SECTOR,
	input wire logic                  DONE,
	input wire logic                  PROTECTED,
	input wire prot_pkg::flash_pins_s PINS,
	input wire logic [7:0]            DATA_IN,
	input wire logic [7:0]            DATA_OUT,
	input wire logic                  DATA_OE_N
);
	// long pulses exceed repetition limits, so count them
	logic [23:0] low_ff;
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			low_ff <= 24'h0;
		else
			low_ff <= PINS.we_n ? 24'h0 : low_ff + 24'h1;
	end
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	a_prot_entry: assert property ($fell(PINS.we_n) && !PINS.hv_ce
		|-> PINS.hv_addr && PINS.hv_oe && !PINS.ce_n) else $error("bad entry");
	a_prot_width: assert property ($rose(PINS.we_n) && !PINS.hv_ce
		|-> low_ff == PROT_CYC) else $error("protect width");
	a_unprot_width: assert property ($rose(PINS.we_n) && PINS.hv_ce
		|-> low_ff == UNPROT_CYC) else $error("unprotect width");
	a_unprot_bits: assert property ($fell(PINS.we_n) && PINS.hv_ce
		|-> PINS.addr[6] && PINS.addr[12] && PINS.addr[16] && PINS.hv_oe)
		else $error("unprotect bits");
	a_hold_stable: assert property (!PINS.we_n && !$past(PINS.we_n)
		|-> $stable(PINS.addr) && $stable(DATA_OUT)) else $error("moved");
	a_verify_pins: assert property (!PINS.oe_n |-> PINS.hv_addr
		&& !PINS.hv_oe && !PINS.ce_n && PINS.we_n && !PINS.addr[0]
		&& PINS.addr[1]) else $error("verify pins");
	a_done_pulse: assert property (DONE |=> !DONE && CMD_READY)
		else $error("done pulse");
	a_result_hold: assert property (PROTECTED != $past(PROTECTED) |-> DONE)
		else $error("result moved");
	a_no_clash: assert property (!DATA_OE_N |-> PINS.oe_n)
		else $error("data clash");
endmodule : prot_host_props
bind prot_host prot_host_props #(.PROT_CYC(PROT_CYC),
	.UNPROT_CYC(UNPROT_CYC)) u_props (.*);
`default_nettype wire

// ---- sim/flash_sector_protection_tb.sv ----
/* self-checking bench for prot_host against flash_model.
 assumes the shortened pulse counts set below */
`timescale 1ns/10ps
`default_nettype none
module flash_sector_protection_tb;
	logic                  clock, rst_n, valid, ready, done, prot, oe_n;
	prot_pkg::prot_cmd_e   op;
	prot_pkg::flash_pins_s pins;
	logic [2:0]            sec;
	logic [7:0]            din, dout, seed, pm;
	logic [1:0]            q[$];
	int                    err_count, n_tests;
	prot_host #(.PROT_CYC(50), .UNPROT_CYC(100)) u_dut (.CLOCK(clock),
		.RST_N(rst_n), .CMD_VALID(valid), .CMD_READY(ready), .CMD_OP(op),
		.CMD_SECTOR(sec), .DONE(done), .PROTECTED(prot), .PINS(pins),
		.DATA_IN(din), .DATA_OUT(dout), .DATA_OE_N(oe_n));
	flash_model u_flash (.clk(clock), .pins(pins), .dout(dout),
		.dout_oe_n(oe_n), .din(din));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	task automatic summarize();
		$display("errors %0d tests %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize
	task automatic chk(input logic [1:0] e, input logic g);
		n_tests++;
		if (g !== e[0]) begin
			err_count++;
			$display("[ERR] %0t exp %h got %h", $time, e[0], g);
		end
	endtask : chk
	// e[1] marks a verify, e[0] the expected answer
	task automatic run(input prot_pkg::prot_cmd_e o, input logic [2:0] s,
		input logic [1:0] e);
		@(negedge clock);
		while (ready !== 1'b1) @(negedge clock);
		q.push_back(e);
		op <= o;
		sec <= s;
		valid <= 1'b1;
		@(negedge clock);
		valid <= 1'b0;
		while (done !== 1'b1) @(negedge clock);
	endtask : run
	always @(negedge clock) begin : mon
		logic [1:0] e;
		if (done === 1'b1 && q.size() > 0) begin
			e = q.pop_front();
			if (e[1]) chk(e, prot);
		end
	end
	initial begin
		#200000;
		err_count++;
		summarize();
	end
	initial begin
		err_count = 0;
		n_tests = 0;
		rst_n = 1'b0;
		valid = 1'b0;
		op = prot_pkg::CMD_PROTECT;
		sec = 3'h0;
		seed = 8'h1A;
		pm = 8'h00;
		repeat (4) @(posedge clock);
		@(negedge clock) rst_n <= 1'b1;
		for (int i = 0; i < 8; i++) run(prot_pkg::CMD_VERIFY_P, 3'(i), 2'h2);
		repeat (4) begin
			seed = lfsr(seed);
			pm[seed[2:0]] = 1'b1;
			run(prot_pkg::CMD_PROTECT, seed[2:0], 2'h0);
		end
		for (int i = 0; i < 8; i++) run(prot_pkg::CMD_VERIFY_P, 3'(i), {1'b1, pm[i]});
		run(prot_pkg::CMD_UNPROTECT, 3'h0, 2'h0);
		run(prot_pkg::CMD_VERIFY_P, seed[2:0], 2'h3);
		for (int i = 0; i < 8; i++) run(prot_pkg::CMD_PROTECT, 3'(i), 2'h0);
		run(prot_pkg::CMD_VERIFY_U, 3'h5, 2'h3);
		seed = lfsr(seed);
		run(prot_pkg::CMD_UNPROTECT, seed[2:0], 2'h0);
		for (int i = 0; i < 8; i++) run(prot_pkg::CMD_VERIFY_U, 3'(i), 2'h2);
		summarize();
	end
endmodule : flash_sector_protection_tb
`default_nettype wire
